// File: hdl/vc_arb_pkg.sv
// constants, types and register map of the channel arbitration register bank
package vc_arb_pkg;

    // register byte addresses
    localparam logic [31:0] ADDR_CAP_TWO  = 32'h0000_0148;
    localparam logic [31:0] ADDR_CTRL     = 32'h0000_014c;
    localparam logic [31:0] ADDR_RES_ZERO = 32'h0000_0150;

    // channel capability two fields
    localparam int          ARB_CAP_LSB   = 0;
    localparam int          TBL_OFF_LSB   = 24;
    localparam logic [7:0]  ARB_CAP_ON    = 8'h03;
    localparam logic [7:0]  ARB_CAP_OFF   = 8'h00;
    localparam logic [7:0]  TBL_OFF_ON    = 8'h03;
    localparam logic [7:0]  TBL_OFF_OFF   = 8'h00;

    // control and status fields
    localparam int          LOAD_BIT      = 0;
    localparam int          SEL_LSB       = 1;
    localparam int          SEL_W         = 3;
    localparam int          STATUS_BIT    = 16;
    localparam logic [2:0]  SEL_DEFAULT   = 3'h0;
    localparam logic [2:0]  SEL_ALT       = 3'h1;

    // resource zero capability fields
    localparam int          PORT_CAP_LSB  = 0;
    localparam int          AS_BIT        = 14;
    localparam int          SNOOP_BIT     = 15;
    localparam int          SLOTS_LSB     = 16;
    localparam int          SLOTS_W       = 7;
    localparam int          PORT_OFF_LSB  = 24;
    localparam logic [7:0]  PORT_CAP_RST  = 8'h19;
    localparam logic [6:0]  SLOTS_RST     = 7'h7f;
    localparam logic [7:0]  PORT_OFF_RST  = 8'h04;

    // strap sampling: last counter value at which the strap still follows the pin; it freezes after three edges
    localparam logic [1:0]  STRAP_SETTLE  = 2'h2;

    // ahb-lite constants
    localparam logic [1:0]  HRESP_OKAY    = 2'h0;

    typedef enum logic [1:0] {
        REG_NONE,
        REG_CAP_TWO,
        REG_CTRL,
        REG_RES_ZERO
    } reg_id_t;

    // one ahb-lite address phase
    typedef struct packed {
        logic        sel;
        logic [1:0]  trans;
        logic        write;
        logic [2:0]  size;
        logic [31:0] addr;
    } ahb_req_t;

    // whole state of the register bank
    typedef struct packed {
        logic        sync_a;
        logic        sync_b;
        logic [1:0]  strap_cnt;
        logic        strap;
        logic        ctrl_write;
        logic [2:0]  select;
        logic        load_pulse;
        logic        load_pending;
        logic        table_status;
        logic [6:0]  slots;
        logic        cap_valid;
        logic        hreadyout;
        logic [31:0] hrdata;
    } state_t;

endpackage : vc_arb_pkg

// File: hdl/vc_arbitration_config_regs.sv
// channel arbitration capability, control and status registers on ahb-lite
//
// Summary of operation
// - channel arbitration capability resets from second-channel strap
// - capability valid only with low-priority channels
// - advertise round robin and 32-phase weighted scheme
// - channel table offset at 31:24, strap-dependent
// - load bit triggers table load, reads 0
// - select accepts 0 or 1, else default
// - table status sets on entry write, clears on load
// - port arbitration capability reads 19h
// - advanced switching bit reads zero
// - reject snoop bit reads zero
// - max time slots 7fh, autoload may override
// - port table offset reads 04h
// - strap bit sampled from pin at reset
//
// bus behaviour
// - single-word transfers only, hsize is not looked at
// - an address phase is taken on hsel, htrans nonseq or seq and hready
// - no wait states: hreadyout is high from reset on
// - the response is always okay, also for unmapped words
// - write data land at the edge that closes the data phase
// - read data are registered at the address edge
// - read data hold until the next read is taken
// - a read right behind a control write sees the new value
//
// register map
// - capability two: read only, strap-dependent fields
// - control and status share one word, control in the low half
// - resource zero capability: read only, slot count may be reloaded
// - every other address reads zero and drops writes
//
// strap handling
// - the pin is asynchronous and passes two flops first
// - the captured bit follows the synchronised pin for three edges
// - after that it holds until the next reset
// - capability words are settled from the third edge after release
// - a pin that moves later has no effect, by intent
//
// table handshake
// - a control write with the load bit pulses the load strobe once
// - the same write opens a load request
// - a finishing load closes the request and clears the status
// - a finishing load with no open request is ignored
// - an entry write in the same cycle as a finishing load wins
// - a new load written with a finishing load keeps the request open
//
// limitations
// - the arbitration engines and the tables live outside this block
// - select keeps only the two supported schemes, others fall to default
// - the capability valid output only reports, the field reads regardless
// - the slot count reload has no bus path, only the autoload port
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module vc_arbitration_config_regs
    import vc_arb_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    // ahb-lite slave
    input  wire logic              i_hsel,
    input  wire logic [31:0]       i_haddr,
    input  wire logic [1:0]        i_htrans,
    input  wire logic              i_hwrite,
    input  wire logic [2:0]        i_hsize,
    input  wire logic [31:0]       i_hwdata,
    input  wire logic              i_hready,
    output logic                   o_hreadyout,
    output logic [1:0]             o_hresp,
    output logic [31:0]            o_hrdata,
    // strap pin, asynchronous
    input  wire logic              i_second_channel_strap,
    // core side, same clock
    input  wire logic [2:0]        i_low_priority_channel_group,
    input  wire logic              i_table_entry_write,
    input  wire logic              i_table_load_done,
    input  wire logic              i_autoload_slots_valid,
    input  wire logic [SLOTS_W-1:0] i_autoload_slots,
    output logic                   o_second_channel,
    output logic                   o_arb_cap_valid,
    output logic [SEL_W-1:0]       o_arb_select,
    output logic                   o_load_table,
    output logic                   o_table_status
);

    ////////////////////////////////////////////////////////////////////////
    // address decode

    // one decode serves both the read path and the write capture
    function automatic reg_id_t decode(input logic [31:0] addr);
        reg_id_t id;
        id = REG_NONE;
        case (addr)
            ADDR_CAP_TWO:  id = REG_CAP_TWO;
            ADDR_CTRL:     id = REG_CTRL;
            ADDR_RES_ZERO: id = REG_RES_ZERO;
            default:       id = REG_NONE;
        endcase
        return id;
    endfunction : decode

    // nonseq and seq both carry a transfer; idle and busy do not
    function automatic logic is_transfer(input logic [1:0] trans);
        return trans[1];
    endfunction : is_transfer

    // only the two supported schemes survive; anything else is the default
    function automatic logic [SEL_W-1:0] legal_select(input logic [SEL_W-1:0] v);
        logic [SEL_W-1:0] r;
        r = SEL_DEFAULT;
        if (v == SEL_ALT) begin
            r = SEL_ALT;
        end
        return r;
    endfunction : legal_select

    ////////////////////////////////////////////////////////////////////////
    // read value assembly

    // capability word two; both fields follow the captured strap
    function automatic logic [31:0] cap_two_word(input logic strap);
        logic [31:0] w;
        w = 32'h0;
        w[ARB_CAP_LSB +: 8] = strap ? ARB_CAP_ON : ARB_CAP_OFF;
        w[TBL_OFF_LSB +: 8] = strap ? TBL_OFF_ON : TBL_OFF_OFF;
        return w;
    endfunction : cap_two_word

    // control in the low half, status in the high half of one word
    function automatic logic [31:0] ctrl_word(input logic [SEL_W-1:0] sel, input logic status);
        logic [31:0] w;
        w = 32'h0;
        w[LOAD_BIT]         = 1'b0;
        w[SEL_LSB +: SEL_W] = sel;
        w[STATUS_BIT]       = status;
        return w;
    endfunction : ctrl_word

    // resource capability; only the slot count can move
    function automatic logic [31:0] res_zero_word(input logic [SLOTS_W-1:0] slots);
        logic [31:0] w;
        w = 32'h0;
        w[PORT_CAP_LSB +: 8]    = PORT_CAP_RST;
        w[AS_BIT]               = 1'b0;
        w[SNOOP_BIT]            = 1'b0;
        w[SLOTS_LSB +: SLOTS_W] = slots;
        w[PORT_OFF_LSB +: 8]    = PORT_OFF_RST;
        return w;
    endfunction : res_zero_word

    // builds a register word from the state; unlisted bits stay zero
    function automatic logic [31:0] read_word(input reg_id_t id, input state_t s);
        logic [31:0] w;
        w = 32'h0;
        case (id)
            REG_CAP_TWO:  w = cap_two_word(s.strap);
            REG_CTRL:     w = ctrl_word(s.select, s.table_status);
            REG_RES_ZERO: w = res_zero_word(s.slots);
            default:      w = 32'h0;
        endcase
        return w;
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////
    // state

    state_t   s;
    state_t   next_s;
    ahb_req_t req;
    reg_id_t  req_id;
    logic     req_valid;
    logic [SEL_W-1:0] wr_sel;

    // bundle the address phase
    assign req       = '{sel: i_hsel, trans: i_htrans, write: i_hwrite,
                         size: i_hsize, addr: i_haddr};
    assign req_valid = req.sel && is_transfer(req.trans) && i_hready;
    assign req_id    = decode(req.addr);
    assign wr_sel    = i_hwdata[SEL_LSB +: SEL_W];

    ////////////////////////////////////////////////////////////////////////
    // decoded events

    logic req_write;
    logic req_read;
    logic load_write;
    logic load_close;
    logic status_set;
    logic status_clear;
    logic strap_open;

    // address phase split by direction
    assign req_write    = req_valid && req.write;
    assign req_read     = req_valid && !req.write;
    // a load written together with a finishing load keeps the request open
    assign load_write   = s.ctrl_write && i_hwdata[LOAD_BIT];
    assign load_close   = i_table_load_done && s.load_pending && !load_write;
    // set and clear decoded apart so the set can win
    assign status_set   = i_table_entry_write;
    assign status_clear = i_table_load_done && s.load_pending;
    // two synchroniser edges plus the capture edge; a shorter window froze zero
    assign strap_open   = (s.strap_cnt <= STRAP_SETTLE);

    ////////////////////////////////////////////////////////////////////////
    // next state

    // writes are applied first so a read right behind a write sees new data
    always_comb begin
        next_s = s;

        // two-stage synchroniser for the strap pin
        next_s.sync_a = i_second_channel_strap;
        next_s.sync_b = s.sync_a;

        // strap follows the pin until settled, then holds until reset
        if (strap_open) begin
            next_s.strap     = s.sync_b;
            next_s.strap_cnt = s.strap_cnt + 2'h1;
        end

        // consumers must ignore the capability with no low-priority group
        next_s.cap_valid = (i_low_priority_channel_group != 3'h0);

        // load request is a single-cycle strobe
        next_s.load_pulse = 1'b0;

        // data phase of a control write; other registers are read only
        if (load_write) begin
            next_s.load_pulse   = 1'b1;
            next_s.load_pending = 1'b1;
        end
        // only the two supported schemes are kept as written
        if (s.ctrl_write) begin
            next_s.select = legal_select(wr_sel);
        end

        // a load completing closes the request; a new one in flight stays
        if (load_close) begin
            next_s.load_pending = 1'b0;
        end

        // entry write beats a finishing load in the same cycle
        if (status_set) begin
            next_s.table_status = 1'b1;
        end else if (status_clear) begin
            next_s.table_status = 1'b0;
        end

        // external configuration memory may replace the slot count
        if (i_autoload_slots_valid) begin
            next_s.slots = i_autoload_slots;
        end

        // capture the address phase; zero wait states, always okay
        next_s.hreadyout  = 1'b1;
        next_s.ctrl_write = req_write && (req_id == REG_CTRL);
        if (req_read) begin
            next_s.hrdata = read_word(req_id, next_s);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // reset values are constants only; the strap is taken after release
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            // every field named, so a new field cannot miss its reset value
            s.sync_a       <= 1'b0;
            s.sync_b       <= 1'b0;
            s.strap_cnt    <= 2'h0;
            s.strap        <= 1'b0;
            s.ctrl_write   <= 1'b0;
            s.select       <= SEL_DEFAULT;
            s.load_pulse   <= 1'b0;
            s.load_pending <= 1'b0;
            s.table_status <= 1'b0;
            s.slots        <= SLOTS_RST;
            s.cap_valid    <= 1'b0;
            s.hreadyout    <= 1'b1;
            s.hrdata       <= 32'h0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flops except the constant hresp

    // bus side; the response never leaves okay
    assign o_hreadyout      = s.hreadyout;
    assign o_hresp          = HRESP_OKAY;
    assign o_hrdata         = s.hrdata;

    // captured strap and capability validity
    assign o_second_channel = s.strap;
    assign o_arb_cap_valid  = s.cap_valid;

    // towards the arbitration engine
    assign o_arb_select     = s.select;
    assign o_load_table     = s.load_pulse;
    assign o_table_status   = s.table_status;

endmodule : vc_arbitration_config_regs

// File: verif/vc_arb_props.sv
// assertions on the channel arbitration register bank ports
`timescale 1ns/10ps
module vc_arb_props
    import vc_arb_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic        o_hreadyout,
    input wire logic [1:0]  o_hresp,
    input wire logic [31:0] o_hrdata,
    input wire logic        i_table_entry_write,
    input wire logic [2:0]  i_low_priority_channel_group,
    input wire logic        o_arb_cap_valid,
    input wire logic [2:0]  o_arb_select,
    input wire logic        o_load_table,
    input wire logic        o_table_status
);
    logic [2:0] ph;
    // data phase kind: write ctrl, read ctrl, read resource zero
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) ph <= 3'h0;
        else ph <= {3{i_hsel & i_htrans[1] & o_hreadyout}} & {i_hwrite, !i_hwrite, !i_hwrite}
            & {i_haddr == ADDR_CTRL, i_haddr == ADDR_CTRL, i_haddr == ADDR_RES_ZERO};
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    AST_ZERO_WAIT: assert property (o_hreadyout && o_hresp == HRESP_OKAY)
        else $error("bus stalled or errored");
    AST_LOAD_PULSE: assert property (o_load_table == ($past(ph[2]) && $past(i_hwdata[0])))
        else $error("load pulse wrong");
    AST_SELECT: assert property (ph[2] |=> o_arb_select == ($past(i_hwdata[3:1]) == SEL_ALT ? SEL_ALT : SEL_DEFAULT))
        else $error("select not stored right");
    AST_STATUS_SET: assert property (i_table_entry_write |=> o_table_status)
        else $error("status not set");
    AST_STATUS_RISE: assert property ($rose(o_table_status) |-> $past(i_table_entry_write))
        else $error("status set without entry write");
    AST_CAP_VALID: assert property (i_nrst |=> o_arb_cap_valid == (|$past(i_low_priority_channel_group)))
        else $error("capability valid wrong");
    AST_CTRL_READ: assert property (ph[1] |-> (o_hrdata & 32'hfffe_fff1) == 32'h0)
        else $error("control read shows stray bits");
    AST_RES_READ: assert property (ph[0] |-> o_hrdata[15:0] == 16'h0019 && o_hrdata[31:23] == 9'h008)
        else $error("resource capability wrong");
endmodule : vc_arb_props

// File: verif/vc_arbitration_config_regs_tb.sv
// self-checking bench of the channel arbitration register bank
`timescale 1ns/10ps
module vc_arbitration_config_regs_tb;
    import vc_arb_pkg::*;
    logic        i_clk = 1'b0, i_nrst = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
    logic        i_second_channel_strap = 1'b0, i_table_entry_write = 1'b0;
    logic        i_table_load_done = 1'b0, i_autoload_slots_valid = 1'b0;
    logic [1:0]  i_htrans = 2'h0, o_hresp;
    logic [2:0]  i_hsize = 3'h2, i_low_priority_channel_group = 3'h0, o_arb_select;
    logic [6:0]  i_autoload_slots = 7'h0;
    logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, rd, o_hrdata;
    logic        o_hreadyout, o_second_channel, o_arb_cap_valid, o_load_table, o_table_status;
    int          n_fail = 0, num_checks = 0;
    always #10 i_clk = ~i_clk;
    vc_arbitration_config_regs uut (
        .i_clk, .i_nrst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
        .i_hready(o_hreadyout), .o_hreadyout, .o_hresp, .o_hrdata, .i_second_channel_strap,
        .i_low_priority_channel_group, .i_table_entry_write, .i_table_load_done,
        .i_autoload_slots_valid, .i_autoload_slots, .o_second_channel, .o_arb_cap_valid,
        .o_arb_select, .o_load_table, .o_table_status);
    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    // bounded wait for hready; a hung slave ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge i_clk);
        while (o_hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                n_fail++;
                print_verdict();
            end
            @(posedge i_clk);
        end
    endtask : wait_ready
    // one single ahb transfer; read data lands in rd
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge i_clk);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_haddr <= a;
        i_hwrite <= wr;
        wait_ready();
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        wait_ready();
        rd = o_hrdata;
    endtask : xfer
    task automatic pulse_done();
        @(posedge i_clk) i_table_load_done <= 1'b1;
        @(posedge i_clk) i_table_load_done <= 1'b0;
    endtask : pulse_done
    // reset under a strap level, then move the pin: capture must hold
    task automatic t_caps(input logic s);
        i_nrst <= 1'b0;
        i_second_channel_strap <= s;
        repeat (20) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_second_channel_strap <= ~s;
        repeat (3) @(posedge i_clk);
        check({31'h0, s}, {31'h0, o_second_channel});
        xfer(1'b0, ADDR_CTRL, 32'h0);
        check(32'h0, rd);
        // second pass proves writes to read-only words are dropped
        for (int k = 0; k < 2; k++) begin
            xfer(1'b0, ADDR_CAP_TWO, 32'h0);
            check(s ? 32'h0300_0003 : 32'h0, rd);
            xfer(1'b0, ADDR_RES_ZERO, 32'h0);
            check(32'h047f_0019, rd);
            xfer(1'b1, ADDR_CAP_TWO, 32'hffff_ffff);
            xfer(1'b1, ADDR_RES_ZERO, 32'hffff_ffff);
        end
    endtask : t_caps
    // every select code with reserved bits set and a load request
    task automatic t_ctrl();
        for (int v = 0; v < 8; v++) begin
            xfer(1'b1, ADDR_CTRL, {28'hfff_ffff, v[2:0], 1'b1});
            #1 check(32'h1, {31'h0, o_load_table});
            check(v == 1 ? 32'h1 : 32'h0, {29'h0, o_arb_select});
            xfer(1'b0, ADDR_CTRL, 32'h0);
            check(v == 1 ? 32'h2 : 32'h0, rd);
            #1 check(32'h0, {31'h0, o_load_table});
        end
    endtask : t_ctrl
    // a done without a load request must not clear the status
    task automatic t_status();
        pulse_done();
        @(posedge i_clk) i_table_entry_write <= 1'b1;
        @(posedge i_clk) i_table_entry_write <= 1'b0;
        pulse_done();
        xfer(1'b0, ADDR_CTRL, 32'h0);
        check(32'h0001_0000, rd);
        xfer(1'b1, ADDR_CTRL, 32'h3);
        pulse_done();
        xfer(1'b0, ADDR_CTRL, 32'h0);
        check(32'h2, rd);
    endtask : t_status
    // autoload of slots, channel group count, unmapped word
    task automatic t_misc();
        i_autoload_slots <= 7'h15;
        i_autoload_slots_valid <= 1'b1;
        i_low_priority_channel_group <= 3'h4;
        @(posedge i_clk) i_autoload_slots_valid <= 1'b0;
        #1 check(32'h1, {31'h0, o_arb_cap_valid});
        xfer(1'b0, ADDR_RES_ZERO, 32'h0);
        check(32'h0415_0019, rd);
        xfer(1'b1, 32'h0000_0154, 32'hffff_ffff);
        xfer(1'b0, 32'h0000_0154, 32'h0);
        check(32'h0, rd);
    endtask : t_misc
    initial begin
        t_caps(1'b1);
        t_caps(1'b0);
        t_ctrl();
        t_status();
        t_misc();
        print_verdict();
    end
endmodule : vc_arbitration_config_regs_tb
bind vc_arbitration_config_regs vc_arb_props props (.i_clk, .i_nrst, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hwdata, .o_hreadyout, .o_hresp, .o_hrdata, .i_table_entry_write,
    .i_low_priority_channel_group, .o_arb_cap_valid, .o_arb_select, .o_load_table, .o_table_status);
